/* File: design/vcr_pkg.sv */
// Purpose: Shared constants for the configuration and video select registers
// Assumes: 16-bit host I/O data, 20-bit host memory address
// Notes: Offsets are host I/O byte addresses
package vcr_pkg;
    localparam logic [15:0] VCR_OFS_STRAP_CFG = 16'h5ae8;
    localparam logic [15:0] VCR_OFS_VID_SEL = 16'h5ee8;
    localparam logic [15:0] VCR_OFS_CURRENT_VERTICAL_POSITION = 16'h82e8;
    // Strapped configuration fields
    localparam int VCR_B_BASE = 3;
    localparam int VCR_B_SIZE = 5;
    localparam int VCR_B_DIR = 6;
    localparam int VCR_B_PLANE = 7;
    localparam int VCR_B_BANKS = 8;
    localparam int VCR_B_VTYPE = 10;
    localparam int VCR_B_FIVE = 11;
    localparam int VCR_B_DAC = 13;
    localparam logic [15:0] VCR_STRAP_MASK = 16'h2fff;
    localparam int VCR_STRAP_W = 17;
    // Video select fields
    localparam int VCR_B_ALT_HIGH_WRITE_SELECT = 4;
    localparam int VCR_B_ALT_LOW_WRITE_SELECT = 5;
    localparam int VCR_B_ALT_HIGH_USE_ENABLE = 6;
    localparam int VCR_B_ALT_LOW_USE_ENABLE = 7;
    localparam int VCR_B_CLK = 8;
    localparam int VCR_B_OVR = 12;
    localparam int VCR_B_MON = 13;
    localparam logic VCR_OVR_RST = 1'b1;
    localparam logic [3:0] VCR_IDX_RST = 4'h0;
    localparam logic [2:0] VCR_CLK_RST = 3'h0;
    localparam logic [11:0] VCR_Y_RST = 12'h000;
    // ROM window: 4K page, window sizes, base table by {base, size, micro_bus}
    localparam int VCR_PAGE_BIT = 12;
    localparam logic [19:0] VCR_WIN_8K = 20'h02000;
    localparam logic [19:0] VCR_WIN_32K = 20'h08000;
    localparam logic [19:0] VCR_ROM_BASE_TBL [16] = '{
        20'hd0000, 20'hd0000, 20'hc6000, 20'hc8000,
        20'hd8000, 20'hd8000, 20'hd8000, 20'hd8000,
        20'hc0000, 20'hc0000, 20'hc0000, 20'hc0000,
        20'hc8000, 20'hc8000, 20'hc8000, 20'hc6000};
    typedef enum logic [1:0] {
        VCR_SET_NORMAL = 2'b00,
        VCR_SET_HIGH = 2'b01,
        VCR_SET_LOW = 2'b10
    } vcr_set_type;
endpackage

/* File: design/vcr_rom_if.sv */
// Purpose: Carries ROM window settings and results to the decoder
// Assumes: One clock domain
// Notes: Purely combinational bundle
`timescale 1ns/1ps
interface vcr_rom_if;
    logic [1:0] base;
    logic size;
    logic size_strap;
    logic micro_bus;
    logic [19:0] mem_addr;
    logic [2:0] page_sel;
    logic hit;
    logic [2:0] page_drive;
    modport dec (input base, size, size_strap, micro_bus, mem_addr, page_sel, output hit, page_drive);
    modport ctl (output base, size, size_strap, micro_bus, mem_addr, page_sel, input hit, page_drive);
endinterface

/* File: design/vcr_strap_latch.sv */
// Purpose: Synchronises strap pins and holds their level caught during reset
// Assumes: Reset held at least three clock edges
// Notes: Live output is the second synchroniser stage
`timescale 1ns/1ps
module vcr_strap_latch #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Pins and results
    input wire logic [W-1:0] pins,
    output logic [W-1:0] live,
    output logic [W-1:0] caught,
    output logic done
);
    logic [W-1:0] meta_r;
    logic [W-1:0] live_r;
    logic [W-1:0] caught_r;
    logic done_r;

    always_ff @(posedge clk_sys) begin
        meta_r <= pins;
        live_r <= meta_r;
    end

    // Follows the pins all through reset, frozen from release on
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            caught_r <= live_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b1;
        end
    end

    assign live = live_r;
    assign caught = caught_r;
    assign done = done_r;

    frozen_after_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $past(resetn) |-> caught_r == $past(caught_r))
        else $error("strap value moved after reset");
endmodule

/* File: design/vcr_rom_dec.sv */
// Purpose: Decodes the expansion ROM window and chooses the page pin value
// Assumes: Host memory address is stable while it is decoded
// Notes: Lower 4K of a window is ROM page zero only when the size strap is set
`timescale 1ns/1ps
module vcr_rom_dec (
    // Settings and results
    vcr_rom_if.dec rom
);
    import vcr_pkg::*;
    logic [19:0] base_addr;
    logic [19:0] win_len;
    logic [19:0] offset;

    always_comb begin
        base_addr = VCR_ROM_BASE_TBL[{rom.base, rom.size, rom.micro_bus}];
        win_len = rom.size ? VCR_WIN_8K : VCR_WIN_32K;
        offset = rom.mem_addr - base_addr;
        rom.hit = (rom.mem_addr >= base_addr) && (offset < win_len);
        if (!rom.size_strap) begin
            rom.page_drive = rom.page_sel;
        end else if (!offset[VCR_PAGE_BIT]) begin
            rom.page_drive = 3'h0;
        end else begin
            rom.page_drive = rom.page_sel;
        end
    end
endmodule

/* File: design/vcr_regs.sv */
// Purpose: Strapped configuration, video timing select and vertical position registers
// Assumes: Host I/O cycles arrive synchronous to clk_sys as one-cycle strobes
// Notes: Read data is registered, valid the cycle after io_rd
//
// What this block does
// - ROM base bits 4:3, strapped, default 11
// - ROM window base from table and bus
// - Page zero fills first 4K of window when size strapped
// - Bit 5 picks 32K or 8K window
// - Upper 4K paged by page select
// - Bit 6 strapped, sets page pin direction
// - Outputs show page select or zero
// - Inputs readable live in status bits 15:13
// - Bit 7 eight plane, strapped, writable
// - Bits 9:8 banks, codes 01/11 interleave
// - Bit 10 VRAM type, strapped
// - Bit 11 five pixel, needs memory bit
// - Bit 13 DAC width, strapped
// - Bits 3:0 pick multifunction read index
// - Bits 4/5 redirect writes, both block
// - Function write chooses alternate set used
// - Three clock select sets, view selected
// - Override bit forces normal set
// - Function control write clears override
// - Display code bits 15:13 latched or live
// - Y position bits 11:0, rest zero
// - Registers at 5AE8h, 5EE8h and 82E8h
`timescale 1ns/1ps
module vcr_regs (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Host I/O port
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [1:0] io_be,
    input wire logic [15:0] io_wdata,
    output logic [15:0] io_rdata,
    output logic io_hit,
    // Host memory cycle for the ROM window
    input wire logic [19:0] mem_addr,
    input wire logic micro_bus,
    output logic rom_select,
    // Strap pins
    input wire logic [2:0] strap_pins_low,
    input wire logic [1:0] strap_pins_four_three,
    input wire logic strap_pin_five,
    input wire logic strap_pin_six,
    input wire logic strap_pin_seven,
    input wire logic column_strobe_three_n,
    input wire logic column_strobe_two_n,
    input wire logic memory_address_bit_eight,
    input wire logic write_enable_four_n,
    input wire logic wide_dac_pin,
    // ROM page pins
    input wire logic [2:0] rom_page_pins_in,
    output logic [2:0] rom_page_pins_out,
    output logic [2:0] rom_page_pins_oe,
    // From neighbouring registers
    input wire logic [2:0] rom_page_select,
    input wire logic memory_control_bit0,
    input wire logic afc_write,
    input wire logic afc_clock_choice0,
    // Configuration outputs
    output logic [15:0] strapped_memory_rom_config,
    output logic [2:0] subsystem_status_id,
    output logic eight_plane_status,
    output logic horizontal_interleave,
    output logic five_pixel_grouping,
    output logic wide_dac_select,
    output logic [3:0] mfc_read_index,
    output logic alt_high_write_select,
    output logic alt_low_write_select,
    output logic timing_access_block,
    output vcr_pkg::vcr_set_type video_set,
    output logic [2:0] pixel_clock_choice,
    output logic [11:0] current_vertical_position
);
    import vcr_pkg::*;

    logic [VCR_STRAP_W-1:0] strap_pins;
    logic [VCR_STRAP_W-1:0] strap_live;
    logic [VCR_STRAP_W-1:0] strap_caught;
    logic strap_done;
    logic [15:0] cfg_r;
    logic [3:0] idx_r;
    logic alt_high_write_select_r, alt_low_write_select_r, alt_high_use_enable_r, alt_low_use_enable_r, ovr_r;
    logic [2:0] clk_norm_r, clk_high_r, clk_low_r;
    logic [2:0] mon_r;
    logic [11:0] y_r;
    vcr_set_type set_r;
    logic [15:0] rdata_r;
    logic hit_r;
    logic sel_cfg, sel_vid, sel_y;
    logic wr_lo, wr_hi;
    logic [2:0] clk_view;
    logic [2:0] mon_view;
    logic [15:0] cfg_view, vid_view;

    // Strap pins gathered into one vector
    // Bit positions line up with the strapped register, bit 12 has no pin
    assign strap_pins = {rom_page_pins_in, wide_dac_pin, 1'b0, write_enable_four_n, memory_address_bit_eight,
        column_strobe_three_n, column_strobe_two_n, strap_pin_seven, strap_pin_six, strap_pin_five,
        strap_pins_four_three, strap_pins_low};

    vcr_strap_latch #(.W(VCR_STRAP_W)) u_strap (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .pins(strap_pins),
        .live(strap_live),
        .caught(strap_caught),
        .done(strap_done)
    );

    always_comb begin
        sel_cfg = 1'b0;
        sel_vid = 1'b0;
        sel_y = 1'b0;
        if (io_addr == VCR_OFS_STRAP_CFG) begin
            sel_cfg = 1'b1;
        end else if (io_addr == VCR_OFS_VID_SEL) begin
            sel_vid = 1'b1;
        end else if (io_addr == VCR_OFS_CURRENT_VERTICAL_POSITION) begin
            sel_y = 1'b1;
        end
    end
    assign wr_lo = io_wr && io_be[0];
    assign wr_hi = io_wr && io_be[1];

    // strapped fields, loaded while reset is low
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cfg_r <= strap_caught[15:0] & VCR_STRAP_MASK;
        end else begin
            if (sel_cfg && wr_lo) begin
                cfg_r[7:3] <= io_wdata[7:3];
            end
            if (sel_cfg && wr_hi) begin
                cfg_r[15:8] <= io_wdata[15:8] & VCR_STRAP_MASK[15:8];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            idx_r <= VCR_IDX_RST;
            alt_high_write_select_r <= 1'b0;
            alt_low_write_select_r <= 1'b0;
            alt_high_use_enable_r <= 1'b0;
            alt_low_use_enable_r <= 1'b0;
        end else if (sel_vid && wr_lo) begin
            idx_r <= io_wdata[3:0];
            alt_high_write_select_r <= io_wdata[VCR_B_ALT_HIGH_WRITE_SELECT];
            alt_low_write_select_r <= io_wdata[VCR_B_ALT_LOW_WRITE_SELECT];
            alt_high_use_enable_r <= io_wdata[VCR_B_ALT_HIGH_USE_ENABLE];
            alt_low_use_enable_r <= io_wdata[VCR_B_ALT_LOW_USE_ENABLE];
        end
    end

    // three clock select sets; a word write sees the old selects
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            clk_norm_r <= VCR_CLK_RST;
            clk_high_r <= VCR_CLK_RST;
            clk_low_r <= VCR_CLK_RST;
        end else begin
            if (sel_vid && wr_hi) begin
                if (alt_high_write_select_r && !alt_low_write_select_r) begin
                    clk_high_r <= io_wdata[VCR_B_CLK +: 3];
                end else if (alt_low_write_select_r && !alt_high_write_select_r) begin
                    clk_low_r <= io_wdata[VCR_B_CLK +: 3];
                end else if (!alt_high_write_select_r && !alt_low_write_select_r) begin
                    clk_norm_r <= io_wdata[VCR_B_CLK +: 3];
                end
            end
            if (afc_write) begin
                clk_norm_r[0] <= afc_clock_choice0;
            end
        end
    end

    // override resets high; cleared by function write
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ovr_r <= VCR_OVR_RST;
        end else if (afc_write) begin
            ovr_r <= 1'b0;
        end else if (sel_vid && wr_hi) begin
            ovr_r <= io_wdata[VCR_B_OVR];
        end
    end

    // function write picks set in use
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            set_r <= VCR_SET_NORMAL;
        end else if (afc_write) begin
            if (alt_high_use_enable_r && afc_clock_choice0) begin
                set_r <= VCR_SET_HIGH;
            end else if (alt_low_use_enable_r && !afc_clock_choice0) begin
                set_r <= VCR_SET_LOW;
            end else begin
                set_r <= VCR_SET_NORMAL;
            end
        end
    end

    // display code, writable only when latched
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            mon_r <= strap_caught[16:14];
        end else if (sel_vid && wr_hi && cfg_r[VCR_B_DIR]) begin
            mon_r <= io_wdata[VCR_B_MON +: 3];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            y_r <= VCR_Y_RST;
        end else begin
            if (sel_y && wr_lo) begin
                y_r[7:0] <= io_wdata[7:0];
            end
            if (sel_y && wr_hi) begin
                y_r[11:8] <= io_wdata[11:8];
            end
        end
    end

    // view follows the single active write select
    always_comb begin
        if (alt_high_write_select_r && !alt_low_write_select_r) begin
            clk_view = clk_high_r;
        end else if (alt_low_write_select_r && !alt_high_write_select_r) begin
            clk_view = clk_low_r;
        end else begin
            clk_view = clk_norm_r;
        end
    end

    // live pins when they are inputs
    assign mon_view = cfg_r[VCR_B_DIR] ? mon_r : strap_live[16:14];
    assign cfg_view = {cfg_r[15:3], strap_caught[2:0]} & VCR_STRAP_MASK;
    assign vid_view = {mon_view, ovr_r, 1'b0, clk_view, alt_low_use_enable_r, alt_high_use_enable_r, alt_low_write_select_r, alt_high_write_select_r, idx_r};

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rdata_r <= 16'h0000;
            hit_r <= 1'b0;
        end else begin
            hit_r <= (io_rd || io_wr) && (sel_cfg || sel_vid || sel_y);
            if (io_rd) begin
                if (sel_cfg) begin
                    rdata_r <= cfg_view;
                end else if (sel_vid) begin
                    rdata_r <= vid_view;
                end else if (sel_y) begin
                    rdata_r <= {4'h0, y_r};
                end else begin
                    rdata_r <= 16'h0000;
                end
            end
        end
    end

    vcr_rom_if rom_if ();
    assign rom_if.base = cfg_r[VCR_B_BASE +: 2];
    assign rom_if.size = cfg_r[VCR_B_SIZE];
    assign rom_if.size_strap = strap_caught[VCR_B_SIZE];
    assign rom_if.micro_bus = micro_bus;
    assign rom_if.mem_addr = mem_addr;
    assign rom_if.page_sel = rom_page_select;

    vcr_rom_dec u_dec (
        .rom(rom_if.dec)
    );

    logic pins_drive;
    // outputs only after code is latched
    assign pins_drive = strap_caught[VCR_B_DIR] && strap_done;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rom_page_pins_out <= 3'h0;
        end else begin
            rom_page_pins_out <= rom_if.page_drive;
        end
    end

    assign rom_page_pins_oe = {3{pins_drive}};
    assign rom_select = rom_if.hit;
    assign io_rdata = rdata_r;
    assign io_hit = hit_r;
    assign strapped_memory_rom_config = cfg_view;
    assign subsystem_status_id = mon_view;
    assign eight_plane_status = strap_caught[VCR_B_PLANE];
    // interleave on codes 01 and 11
    assign horizontal_interleave = cfg_r[VCR_B_BANKS];
    // five pixel needs memory control bit
    assign five_pixel_grouping = cfg_r[VCR_B_FIVE] && memory_control_bit0;
    assign wide_dac_select = cfg_r[VCR_B_DAC];
    assign mfc_read_index = idx_r;
    assign alt_high_write_select = alt_high_write_select_r && !alt_low_write_select_r;
    assign alt_low_write_select = alt_low_write_select_r && !alt_high_write_select_r;
    assign timing_access_block = alt_high_write_select_r && alt_low_write_select_r;
    assign video_set = ovr_r ? VCR_SET_NORMAL : set_r;
    assign pixel_clock_choice = (video_set == VCR_SET_HIGH) ? clk_high_r :
        (video_set == VCR_SET_LOW) ? clk_low_r : clk_norm_r;
    assign current_vertical_position = y_r;

    ovr_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        afc_write |=> !ovr_r) else $error("override not cleared by function write");
    ovr_force_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        ovr_r |-> video_set == VCR_SET_NORMAL) else $error("override did not force normal set");
    alt_pick_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        afc_write && alt_high_use_enable_r && afc_clock_choice0 |=> set_r == VCR_SET_HIGH)
        else $error("alternate high set not chosen");
    both_block_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        alt_high_write_select_r && alt_low_write_select_r && sel_vid && wr_hi && !afc_write |=> $stable(clk_norm_r) && $stable(clk_high_r)
        && $stable(clk_low_r))
        else $error("clock select written while access blocked");
    y_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        io_rd && sel_y |=> io_rdata[15:12] == 4'h0 && io_rdata[11:0] == $past(y_r))
        else $error("vertical position read wrong");
    mon_live_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !cfg_r[VCR_B_DIR] |-> subsystem_status_id == strap_live[16:14])
        else $error("display code not live");
    pin_dir_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        rom_page_pins_oe != 3'h0 |-> strap_caught[VCR_B_DIR] && strap_done)
        else $error("page pins driven while inputs");
    page_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !strap_caught[VCR_B_SIZE] ##1 !strap_caught[VCR_B_SIZE] |-> rom_page_pins_out == $past(rom_page_select))
        else $error("page pins not showing page select");
    five_px_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        five_pixel_grouping |-> memory_control_bit0) else $error("five pixel without memory bit");
endmodule

/* File: tb/vcr_host_model.sv */
// Purpose: Host processor model issuing I/O cycles to the register block
// Assumes: Strobes sampled on the rising edge, answer ready one cycle later
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module vcr_host_model (
    // Clock
    input wire logic clk_sys,
    // Host I/O port
    output logic [15:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [1:0] io_be,
    output logic [15:0] io_wdata,
    input wire logic [15:0] io_rdata,
    input wire logic io_hit
);
    initial begin
        io_addr = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_be = 2'b00;
        io_wdata = 16'h0000;
    end

    task automatic cycle(input logic wr, input logic [15:0] a, input logic [1:0] be, input logic [15:0] d,
                         output logic [15:0] q, output logic hit);
        @(negedge clk_sys);
        io_wr = wr;
        io_rd = ~wr;
        io_addr = a;
        io_be = be;
        io_wdata = d;
        @(negedge clk_sys);
        q = io_rdata;
        hit = io_hit;
        io_wr = 1'b0;
        io_rd = 1'b0;
        // Stale bus must not look like a valid cycle
        io_addr = ~a;
        io_wdata = ~d;
    endtask
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the strapped config, video select and Y registers
// Assumes: Host model drives the I/O port, bench drives straps and neighbour levels
// Notes: Inputs change on the falling edge
`timescale 1ns/1ps
module testbench;
    import vcr_pkg::*;
    logic clk_sys, resetn, io_wr, io_rd, io_hit, micro_bus, rom_select, strap_pin_five, strap_pin_six;
    logic [15:0] io_addr, io_wdata, io_rdata, strapped_memory_rom_config;
    logic [1:0] io_be, strap_pins_four_three;
    logic [19:0] mem_addr;
    logic [2:0] strap_pins_low, rom_page_pins_in, rom_page_pins_out, rom_page_pins_oe, page_ext;
    logic [2:0] rom_page_select, subsystem_status_id, pixel_clock_choice;
    logic strap_pin_seven, column_strobe_three_n_n, column_strobe_two_n_n, ma8, we4_n, wide_dac_pin, memory_control_bit0, afc_write;
    logic afc_clock_choice0, eight_plane_status, horizontal_interleave, five_pixel_grouping;
    logic wide_dac_select, alt_high_write_select, alt_low_write_select, timing_access_block;
    logic [3:0] mfc_read_index;
    logic [11:0] current_vertical_position;
    vcr_set_type video_set;
    int err_count = 0;
    int compares = 0;

    // Wire level from the block's enables, external level otherwise
    assign rom_page_pins_in = (rom_page_pins_oe & rom_page_pins_out) | (~rom_page_pins_oe & page_ext);

    vcr_host_model host (.clk_sys(clk_sys), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_be(io_be),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit));

    vcr_regs dut (.clk_sys(clk_sys), .resetn(resetn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_be(io_be), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit), .mem_addr(mem_addr),
        .micro_bus(micro_bus), .rom_select(rom_select), .strap_pins_low(strap_pins_low),
        .strap_pins_four_three(strap_pins_four_three), .strap_pin_five(strap_pin_five),
        .strap_pin_six(strap_pin_six), .strap_pin_seven(strap_pin_seven), .column_strobe_three_n(column_strobe_three_n_n),
        .column_strobe_two_n(column_strobe_two_n_n), .memory_address_bit_eight(ma8), .write_enable_four_n(we4_n),
        .wide_dac_pin(wide_dac_pin), .rom_page_pins_in(rom_page_pins_in), .rom_page_pins_out(rom_page_pins_out),
        .rom_page_pins_oe(rom_page_pins_oe), .rom_page_select(rom_page_select),
        .memory_control_bit0(memory_control_bit0), .afc_write(afc_write), .afc_clock_choice0(afc_clock_choice0),
        .strapped_memory_rom_config(strapped_memory_rom_config), .subsystem_status_id(subsystem_status_id),
        .eight_plane_status(eight_plane_status), .horizontal_interleave(horizontal_interleave),
        .five_pixel_grouping(five_pixel_grouping), .wide_dac_select(wide_dac_select),
        .mfc_read_index(mfc_read_index), .alt_high_write_select(alt_high_write_select),
        .alt_low_write_select(alt_low_write_select), .timing_access_block(timing_access_block),
        .video_set(video_set), .pixel_clock_choice(pixel_clock_choice),
        .current_vertical_position(current_vertical_position));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic wrap_up();
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [1:0] be, input logic [15:0] d);
        logic [15:0] q;
        logic h;
        host.cycle(1'b1, a, be, d, q, h);
        chk(16'(h), 16'h0001);
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] q;
        logic h;
        host.cycle(1'b0, a, 2'b11, 16'h0000, q, h);
        chk(16'(h), 16'h0001);
        chk(q, exp);
    endtask

    task automatic do_reset(input logic six);
        @(negedge clk_sys);
        strap_pin_six = six;
        resetn = 1'b0;
        repeat (12) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask

    task automatic afc(input logic c0);
        afc_write = 1'b1;
        afc_clock_choice0 = c0;
        @(negedge clk_sys);
        afc_write = 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic probe(input logic [19:0] a, input logic e);
        mem_addr = a;
        @(negedge clk_sys);
        chk(16'(rom_select), 16'(e));
    endtask

    task automatic t_reset_vals();
        rd(VCR_OFS_STRAP_CFG, 16'h2fff);
        rd(VCR_OFS_VID_SEL, 16'hb000);
        chk(16'(rom_page_pins_oe), 16'h0007);
        chk(16'(eight_plane_status), 16'h0001);
        chk(strapped_memory_rom_config, 16'h2fff);
    endtask

    task automatic t_rom_window();
        micro_bus = 1'b0;
        rom_page_select = 3'h5;
        probe(20'hc7fff, 1'b0);
        probe(20'hc8000, 1'b1);
        chk(16'(rom_page_pins_out), 16'h0000);
        probe(20'hc9fff, 1'b1);
        chk(16'(rom_page_pins_out), 16'h0005);
        probe(20'hca000, 1'b0);
        micro_bus = 1'b1;
        probe(20'hc6000, 1'b1);
        probe(20'hc8000, 1'b0);
        micro_bus = 1'b0;
        rd(VCR_OFS_STRAP_CFG, 16'h2fff);
        wr(VCR_OFS_STRAP_CFG, 2'b11, 16'h2fc7);
        probe(20'hd0000, 1'b1);
        probe(20'hd7fff, 1'b1);
        probe(20'hd8000, 1'b0);
        wr(VCR_OFS_STRAP_CFG, 2'b11, 16'h2fff);
    endtask

    task automatic t_strap_fields();
        wr(VCR_OFS_STRAP_CFG, 2'b11, 16'hd0ff);
        rd(VCR_OFS_STRAP_CFG, 16'h00ff);
        chk(16'({horizontal_interleave, wide_dac_select, five_pixel_grouping}), 16'h0000);
        wr(VCR_OFS_STRAP_CFG, 2'b11, 16'h2dff);
        chk(16'(horizontal_interleave), 16'h0001);
        chk(16'(five_pixel_grouping), 16'h0000);
        memory_control_bit0 = 1'b1;
        @(negedge clk_sys);
        chk(16'(five_pixel_grouping), 16'h0001);
        wr(VCR_OFS_STRAP_CFG, 2'b11, 16'h2eff);
        chk(16'(horizontal_interleave), 16'h0000);
        wr(VCR_OFS_STRAP_CFG, 2'b11, 16'h2fff);
    endtask

    task automatic t_video_sel();
        wr(VCR_OFS_VID_SEL, 2'b01, 16'h0010);
        chk(16'({alt_high_write_select, alt_low_write_select, timing_access_block}), 16'h0004);
        wr(VCR_OFS_VID_SEL, 2'b01, 16'h0020);
        chk(16'({alt_high_write_select, alt_low_write_select, timing_access_block}), 16'h0002);
        wr(VCR_OFS_VID_SEL, 2'b01, 16'h003f);
        chk(16'({alt_high_write_select, alt_low_write_select, timing_access_block}), 16'h0001);
        chk(16'(mfc_read_index), 16'h000f);
        rd(VCR_OFS_VID_SEL, 16'hb03f);
        // Clock bits must be ignored while both selects are set
        wr(VCR_OFS_VID_SEL, 2'b10, 16'hb700);
        rd(VCR_OFS_VID_SEL, 16'hb03f);
        wr(VCR_OFS_VID_SEL, 2'b01, 16'h0040);
        afc(1'b1);
        chk(16'(video_set), 16'(VCR_SET_HIGH));
        rd(VCR_OFS_VID_SEL, 16'ha140);
        wr(VCR_OFS_VID_SEL, 2'b01, 16'h0050);
        wr(VCR_OFS_VID_SEL, 2'b10, 16'h0300);
        chk(16'(pixel_clock_choice), 16'h0003);
        chk(16'(subsystem_status_id), 16'h0000);
        wr(VCR_OFS_VID_SEL, 2'b01, 16'h0040);
        rd(VCR_OFS_VID_SEL, 16'h0140);
        afc(1'b0);
        chk(16'(video_set), 16'(VCR_SET_NORMAL));
        chk(16'(pixel_clock_choice), 16'h0000);
        wr(VCR_OFS_VID_SEL, 2'b01, 16'h0080);
        afc(1'b0);
        chk(16'(video_set), 16'(VCR_SET_LOW));
        wr(VCR_OFS_VID_SEL, 2'b10, 16'h1000);
        chk(16'(video_set), 16'(VCR_SET_NORMAL));
        rd(VCR_OFS_VID_SEL, 16'h1080);
    endtask

    task automatic t_y_and_unmapped();
        logic [15:0] q;
        logic h;
        wr(VCR_OFS_CURRENT_VERTICAL_POSITION, 2'b11, 16'hffff);
        rd(VCR_OFS_CURRENT_VERTICAL_POSITION, 16'h0fff);
        wr(VCR_OFS_CURRENT_VERTICAL_POSITION, 2'b10, 16'h0a00);
        rd(VCR_OFS_CURRENT_VERTICAL_POSITION, 16'h0aff);
        chk(16'(current_vertical_position), 16'h0aff);
        host.cycle(1'b0, 16'h86e8, 2'b11, 16'h0000, q, h);
        chk(16'(h), 16'h0000);
        chk(q, 16'h0000);
    endtask

    task automatic t_live_id();
        strap_pin_five = 1'b0;
        do_reset(1'b0);
        chk(16'(rom_page_pins_oe), 16'h0000);
        rd(VCR_OFS_STRAP_CFG, 16'h2f9f);
        chk(16'(rom_page_pins_out), 16'h0005);
        page_ext = 3'b011;
        repeat (5) @(negedge clk_sys);
        chk(16'(subsystem_status_id), 16'h0003);
        rd(VCR_OFS_VID_SEL, 16'h7000);
        wr(VCR_OFS_VID_SEL, 2'b10, 16'he000);
        rd(VCR_OFS_VID_SEL, 16'h6000);
    endtask

    initial begin
        resetn = 1'b0;
        mem_addr = 20'h00000;
        micro_bus = 1'b0;
        strap_pins_low = 3'b111;
        strap_pins_four_three = 2'b11;
        {strap_pin_five, strap_pin_six, strap_pin_seven} = 3'b111;
        {column_strobe_three_n_n, column_strobe_two_n_n, ma8, we4_n, wide_dac_pin} = 5'b11111;
        page_ext = 3'b101;
        rom_page_select = 3'h0;
        memory_control_bit0 = 1'b0;
        afc_write = 1'b0;
        afc_clock_choice0 = 1'b0;
        do_reset(1'b1);
        t_reset_vals();
        t_rom_window();
        t_strap_fields();
        t_video_sel();
        t_y_and_unmapped();
        t_live_id();
        wrap_up();
    end

    // Whole run is about 120 cycles
    initial begin
        #100000;
        err_count++;
        wrap_up();
    end
endmodule
